// ==== include/rbw_pkg.sv ====
// Constants and state encodings for the relay board output controller.
// Assumes a single 100 MHz system clock shared by every user of this package.
package rbw_pkg;

	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned WDOG_TIMEOUT_S = 30;
	localparam logic [63:0] WDOG_CYCLES_64 = 64'(WDOG_TIMEOUT_S) * 64'(CLK_HZ);
	localparam logic [31:0] WDOG_CYCLES    = WDOG_CYCLES_64[31:0];

	// Bit positions of the command byte and of the read-back status byte.
	localparam int unsigned BIT_WHEEL_HEAT = 0;
	localparam int unsigned BIT_BENCH_HEAT = 1;
	localparam int unsigned BIT_SAMPLE_CAL = 2;
	localparam int unsigned BIT_ZERO_SPAN  = 3;
	localparam int unsigned BIT_SHUTOFF    = 4;
	localparam int unsigned BIT_IR_SOURCE  = 5;
	localparam int unsigned BIT_WDOG_IND   = 6;
	localparam int unsigned BIT_TRIPPED    = 7;

	localparam logic [7:0] FORCE_OFF_MASK = 8'h3f;
	localparam logic [7:0] STARTUP_OUT    = 8'h00;
	localparam logic [7:0] RESET_CMD      = 8'h00;
	localparam logic [6:0] I2C_ADDR_DEF   = 7'h20;

	// Line voltage strap codes.
	localparam logic [1:0] LV_100 = 2'h0;
	localparam logic [1:0] LV_115 = 2'h1;
	localparam logic [1:0] LV_230 = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_CHK = 3'b010,
		ST_ACK      = 3'b011,
		ST_WRITE    = 3'b100,
		ST_WR_CHK   = 3'b101,
		ST_READ     = 3'b110,
		ST_RD_MACK  = 3'b111
	} rbw_state_e;

endpackage

// ==== src/rbw_relay_ctrl.sv ====
// Relay board output controller: I2C command slave, switch outputs, indicators and bus watchdog.
// Assumes SCL and SDA arrive from pins (open-drain wired outside) and one 100 MHz clock.
//
// How it works
// - Decode I2C writes into switch and relay outputs.
// - Wheel heater on/off; bench element chosen by voltage.
// - Each valve switch driven by host command, forced off on watchdog trip.
// - IR source on only when commanded on and not tripped.
// - Indicator steady 30 s forces valves, heaters, source off.
// - Wheel motor keeps running through a watchdog shutdown.
// - Heater and source indicators follow outputs; spare dark.
// - Valve indicators follow the valve outputs.
// - Predefined outputs held until first host command.
module rbw_relay_ctrl
	import rbw_pkg::*;
#(
	parameter logic [6:0]  I2C_ADDR   = I2C_ADDR_DEF,
	parameter logic [31:0] WDOG_LIMIT = WDOG_CYCLES
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// I2C pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n_out,
	// Configuration straps and switches
	input  wire logic [1:0] line_volt_sel_in,
	input  wire logic       motor_stop_sw_in,
	// Switch outputs
	output logic            wheel_heat_out,
	output logic            bench_heat_lo_out,
	output logic            bench_heat_hi_out,
	output logic            sample_cal_valve_out,
	output logic            zero_span_valve_out,
	output logic            shutoff_valve_out,
	output logic            ir_source_out,
	output logic            wheel_motor_out,
	output logic            wdog_tripped_out,
	// Status indicators
	output logic            watchdog_indicator_out,
	output logic            wheel_heat_indicator_out,
	output logic            bench_heat_indicator_out,
	output logic            spare_indicator_out,
	output logic            sample_cal_valve_indicator_out,
	output logic            zero_span_valve_indicator_out,
	output logic            shutoff_valve_indicator_out,
	output logic            ir_source_indicator_out
);

	typedef struct packed {
		logic        scl_s1, scl_s2, scl_d;
		logic        sda_s1, sda_s2, sda_d;
		logic [1:0]  lv_s1, lv_s2;
		logic        ms_s1, ms_s2;
		rbw_state_e  st;
		logic [2:0]  cnt;
		logic [7:0]  shreg;
		logic        rw;
		logic        oe_n;
		logic [7:0]  cmd;
		logic [7:0]  eff;
		logic        host_ctrl;
		logic        wd_last;
		logic [31:0] wd_cnt;
		logic        tripped;
		logic        bench_lo, bench_hi, motor;
	} rbw_state_s;

	rbw_state_s r_r, r_nxt;

	logic scl_rise, scl_fall, i2c_start, i2c_stop, wd_toggle, wd_expire, cmd_wr;

	assign scl_rise  = r_r.scl_s2 & ~r_r.scl_d;
	assign scl_fall  = ~r_r.scl_s2 & r_r.scl_d;
	assign i2c_start = r_r.scl_s2 & r_r.scl_d & r_r.sda_d & ~r_r.sda_s2;
	assign i2c_stop  = r_r.scl_s2 & r_r.scl_d & ~r_r.sda_d & r_r.sda_s2;
	assign wd_toggle = r_r.cmd[BIT_WDOG_IND] ^ r_r.wd_last;
	assign wd_expire = ~wd_toggle & (r_r.wd_cnt == WDOG_LIMIT - 32'h0000_0001);
	assign cmd_wr    = (r_r.st == ST_WR_CHK) & scl_fall;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_nxt        = r_r;
		r_nxt.scl_s1 = scl_in;
		r_nxt.scl_s2 = r_r.scl_s1;
		r_nxt.scl_d  = r_r.scl_s2;
		r_nxt.sda_s1 = sda_in;
		r_nxt.sda_s2 = r_r.sda_s1;
		r_nxt.sda_d  = r_r.sda_s2;
		r_nxt.lv_s1  = line_volt_sel_in;
		r_nxt.lv_s2  = r_r.lv_s1;
		r_nxt.ms_s1  = motor_stop_sw_in;
		r_nxt.ms_s2  = r_r.ms_s1;
		r_nxt.wd_last = r_r.cmd[BIT_WDOG_IND];

		// Byte engine: sample on SCL rise, change SDA on SCL fall.
		unique case (r_r.st)
			ST_IDLE: begin
			end
			ST_ADDR, ST_WRITE: begin
				if (scl_rise) begin
					r_nxt.shreg = {r_r.shreg[6:0], r_r.sda_s2};
					r_nxt.cnt   = r_r.cnt + 3'h1;
					if (r_r.cnt == 3'h7) begin
						r_nxt.st = (r_r.st == ST_ADDR) ? ST_ADDR_CHK : ST_WR_CHK;
					end
				end
			end
			ST_ADDR_CHK: begin
				if (scl_fall) begin
					if (r_r.shreg[7:1] == I2C_ADDR) begin
						r_nxt.oe_n = 1'b0;
						r_nxt.rw   = r_r.shreg[0];
						r_nxt.st   = ST_ACK;
					end else begin
						r_nxt.st = ST_IDLE;
					end
				end
			end
			ST_WR_CHK: begin
				if (scl_fall) begin
					r_nxt.cmd       = r_r.shreg;
					r_nxt.host_ctrl = 1'b1;
					r_nxt.oe_n      = 1'b0;
					r_nxt.st        = ST_ACK;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					r_nxt.cnt = 3'h0;
					if (r_r.rw) begin
						r_nxt.shreg = {r_r.tripped, r_r.eff[6:0]};
						r_nxt.oe_n  = r_r.tripped;
						r_nxt.st    = ST_READ;
					end else begin
						r_nxt.oe_n = 1'b1;
						r_nxt.st   = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				if (scl_rise) begin
					r_nxt.cnt = r_r.cnt + 3'h1;
					if (r_r.cnt == 3'h7) begin
						r_nxt.st = ST_RD_MACK;
					end
				end else if (scl_fall) begin
					r_nxt.shreg = {r_r.shreg[6:0], 1'b1};
					r_nxt.oe_n  = r_r.shreg[6];
				end
			end
			ST_RD_MACK: begin
				if (scl_fall) begin
					r_nxt.oe_n = 1'b1;
				end else if (scl_rise) begin
					r_nxt.st = r_r.sda_s2 ? ST_IDLE : ST_ACK;
				end
			end
		endcase
		if (i2c_start) begin
			r_nxt.st   = ST_ADDR;
			r_nxt.cnt  = 3'h0;
			r_nxt.oe_n = 1'b1;
		end else if (i2c_stop) begin
			r_nxt.st   = ST_IDLE;
			r_nxt.oe_n = 1'b1;
		end

		// A fresh command clears the trip flag, but a trip in the same cycle wins.
		if (cmd_wr) begin
			r_nxt.tripped = 1'b0;
		end
		if (wd_toggle) begin
			r_nxt.wd_cnt = 32'h0000_0000;
		end else if (wd_expire) begin
			r_nxt.wd_cnt  = 32'h0000_0000;
			r_nxt.tripped = 1'b1;
			r_nxt.cmd     = r_nxt.cmd & ~FORCE_OFF_MASK;
		end else begin
			r_nxt.wd_cnt = r_r.wd_cnt + 32'h0000_0001;
		end

		r_nxt.eff = r_nxt.host_ctrl ? r_nxt.cmd : STARTUP_OUT;
		if (wd_expire) begin
			r_nxt.eff = r_nxt.eff & ~FORCE_OFF_MASK;
		end
		// The element switch never enables both elements at once.
		r_nxt.bench_hi = r_nxt.eff[BIT_BENCH_HEAT] & (r_r.lv_s2 == LV_230);
		r_nxt.bench_lo = r_nxt.eff[BIT_BENCH_HEAT] & (r_r.lv_s2 != LV_230);
		r_nxt.motor    = ~r_r.ms_s2;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			r_r           <= '0;
			r_r.scl_s1    <= 1'b1;
			r_r.scl_s2    <= 1'b1;
			r_r.scl_d     <= 1'b1;
			r_r.sda_s1    <= 1'b1;
			r_r.sda_s2    <= 1'b1;
			r_r.sda_d     <= 1'b1;
			r_r.st        <= ST_IDLE;
			r_r.oe_n      <= 1'b1;
			r_r.cmd       <= RESET_CMD;
			r_r.eff       <= STARTUP_OUT;
			r_r.motor     <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign sda_out                        = 1'b0;
	assign sda_oe_n_out                   = r_r.oe_n;
	assign wheel_heat_out                 = r_r.eff[BIT_WHEEL_HEAT];
	assign bench_heat_lo_out              = r_r.bench_lo;
	assign bench_heat_hi_out              = r_r.bench_hi;
	assign sample_cal_valve_out           = r_r.eff[BIT_SAMPLE_CAL];
	assign zero_span_valve_out            = r_r.eff[BIT_ZERO_SPAN];
	assign shutoff_valve_out              = r_r.eff[BIT_SHUTOFF];
	assign ir_source_out                  = r_r.eff[BIT_IR_SOURCE];
	assign wheel_motor_out                = r_r.motor;
	assign wdog_tripped_out               = r_r.tripped;
	assign watchdog_indicator_out         = r_r.eff[BIT_WDOG_IND];
	assign wheel_heat_indicator_out       = r_r.eff[BIT_WHEEL_HEAT];
	assign bench_heat_indicator_out       = r_r.eff[BIT_BENCH_HEAT];
	assign spare_indicator_out            = r_r.rw & 1'b0;
	assign sample_cal_valve_indicator_out = r_r.eff[BIT_SAMPLE_CAL];
	assign zero_span_valve_indicator_out  = r_r.eff[BIT_ZERO_SPAN];
	assign shutoff_valve_indicator_out    = r_r.eff[BIT_SHUTOFF];
	assign ir_source_indicator_out        = r_r.eff[BIT_IR_SOURCE];

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_write_apply: assert property (cmd_wr && !wd_expire |=> r_r.host_ctrl && r_r.cmd == $past(r_r.shreg))
		else $error("written command not applied");
	a_bench_select: assert property (bench_heat_hi_out |-> $past(r_r.lv_s2) == LV_230 && !bench_heat_lo_out)
		else $error("bench element select wrong");
	a_valve_cmd: assert property ($changed(zero_span_valve_out) |-> $past(cmd_wr || wd_expire, 1))
		else $error("valve changed without command");
	a_ir_hold: assert property ($fell(ir_source_out) |-> $past(cmd_wr || wd_expire, 1))
		else $error("IR source dropped without cause");
	a_wdog_trip: assert property (wd_expire |=> wdog_tripped_out && (r_r.eff & FORCE_OFF_MASK) == 8'h00)
		else $error("watchdog expiry did not force outputs off");
	a_motor_free: assert property (wd_expire && !r_r.ms_s2 |=> wheel_motor_out)
		else $error("motor stopped by watchdog");
	a_startup_hold: assert property (!r_r.host_ctrl && !$past(wd_expire) |-> r_r.eff == STARTUP_OUT)
		else $error("startup values not held");
	a_wd_restart: assert property (wd_toggle |=> r_r.wd_cnt == 32'h0000_0000 ##1 r_r.wd_cnt == 32'h0000_0001)
		else $error("indicator toggle did not restart timer");
	a_reset_clear: assert property (@(posedge clk_in) disable iff (1'b0) $past(reset_in) |-> r_r.wd_cnt == 32'h0000_0000 && r_r.cmd == RESET_CMD)
		else $error("reset did not clear state");
	a_addr_ack: assert property (r_r.st == ST_ADDR_CHK && scl_fall && r_r.shreg[7:1] == I2C_ADDR |=> !sda_oe_n_out)
		else $error("own address not acknowledged");

	c_trip: cover property (wd_expire ##1 wdog_tripped_out);
	c_write: cover property (cmd_wr ##1 r_r.st == ST_ACK);
	c_read: cover property (r_r.st == ST_READ ##[1:200] r_r.st == ST_RD_MACK);
	c_toggle: cover property (wd_toggle);

endmodule

// ==== dv/rbw_host_model.sv ====
// Behavioural I2C bus master standing in for the host processor.
// Assumes the bench resolves SDA from every open-drain release with a pull-up.
module rbw_host_model (
	// Clock and bus
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_rel_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_out = 1'b1;
		sda_rel_out = 1'b1;
	end
	// Eight cycles a phase keeps each SCL phase well above the four-cycle floor.
	task automatic step(input logic s, input logic c);
		sda_rel_out = s;
		scl_out = c;
		repeat (8) @(negedge clk_in);
	endtask
	// SCL stands high between frames, so a start is only issued from idle.
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
	endtask
	// Nine bits, most significant first; the last is the acknowledge slot.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			step(d[i], 1'b0);
			step(d[i], 1'b1);
			q[i] = sda_in;
			step(d[i], 1'b0);
		end
	endtask
endmodule

// ==== dv/tb_rbw_relay_ctrl.sv ====
// Self-checking bench for the relay board output controller.
// Assumes the host model above and a shortened watchdog limit of 2000 cycles.
module tb_rbw_relay_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import rbw_pkg::*;
	localparam logic [31:0] LIMIT = 32'h0000_07d0;
	logic        clk_in, reset_in, scl, sda_rel, stop_sw, sda_o, oe_n;
	logic [1:0]  lv;
	logic        wh, bl, bh, sc, zs, so, ir, mo, tr, i_wd, i_wh, i_bh, i_sp, i_sc, i_zs, i_so, i_ir;
	logic [7:0]  cmd;
	logic [8:0]  rd_got;
	logic [17:0] q[$];
	int          n_fail, cmp_count, cyc;
	wire logic   sda = sda_rel & (oe_n | sda_o);
	wire logic [16:0] obs = {tr, mo, i_wd, ir, so, zs, sc, bh, bl, wh, i_ir, i_so, i_zs, i_sc, i_bh, i_wh, i_sp};
	rbw_relay_ctrl #(.WDOG_LIMIT(LIMIT)) uut (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_n_out(oe_n), .line_volt_sel_in(lv), .motor_stop_sw_in(stop_sw),
		.wheel_heat_out(wh), .bench_heat_lo_out(bl), .bench_heat_hi_out(bh), .sample_cal_valve_out(sc),
		.zero_span_valve_out(zs), .shutoff_valve_out(so), .ir_source_out(ir), .wheel_motor_out(mo),
		.wdog_tripped_out(tr), .watchdog_indicator_out(i_wd), .wheel_heat_indicator_out(i_wh),
		.bench_heat_indicator_out(i_bh), .spare_indicator_out(i_sp), .sample_cal_valve_indicator_out(i_sc),
		.zero_span_valve_indicator_out(i_zs), .shutoff_valve_indicator_out(i_so), .ir_source_indicator_out(i_ir));
	rbw_host_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_rel_out(sda_rel));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	function automatic logic [16:0] expo(logic [7:0] c, logic t);
		logic on;
		on = c[1];
		return {t, !stop_sw, c[6:2], on && lv == LV_230, on && lv != LV_230, c[0], c[5:2], on, c[0], 1'b0};
	endfunction
	task automatic note(input logic k, input logic [16:0] v);
		q.push_back({k, v});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [8:0] r1, r2;
		host.start();
		host.xfer({a, 1'b1}, r1);
		host.xfer({d, 1'b1}, r2);
		host.stop();
		rd_got = {7'h00, !r1[0], !r2[0]};
	endtask
	task automatic rd();
		logic [8:0] r1, r2;
		host.start();
		host.xfer({I2C_ADDR_DEF, 1'b1, 1'b1}, r1);
		host.xfer(9'h1ff, r2);
		host.stop();
		rd_got = {!r1[0], r2[8:1]};
	endtask
	task automatic cmp_outs(input logic [16:0] g, input logic [16:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_bus(input logic [8:0] g, input logic [8:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Monitor: each note is matched against whatever result the driver just made visible.
	// Waiting on the queue level rather than an event keeps back-to-back notes from being lost.
	initial begin
		logic [17:0] n;
		forever begin
			wait (q.size() != 0);
			n = q.pop_front();
			if (n[17]) cmp_bus(rd_got, n[8:0]);
			else cmp_outs(obs, n[16:0]);
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h0d5c));
		{reset_in, stop_sw, lv, n_fail, cmp_count, cyc, rd_got} = {1'b1, 3'b000, 64'd0, 32'd0, 9'h000};
		repeat (6) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_in);
		note(1'b0, expo(8'h00, 1'b0));
		wr({I2C_ADDR_DEF ^ 7'h01, 1'b0}, 8'h3f);
		note(1'b1, 17'h00000);
		note(1'b0, expo(8'h00, 1'b0));
		for (int i = 0; i < 9; i++) begin
			lv = 2'(i / 3);
			cmd = 8'($urandom());
			stop_sw = cmd[7];
			cmd[6] = i[0];
			wr({I2C_ADDR_DEF, 1'b0}, cmd);
			note(1'b1, 17'h00003);
			note(1'b0, expo(cmd, 1'b0));
			rd();
			note(1'b1, {9'h001, 1'b0, cmd[6:0]});
		end
		stop_sw = 1'b0;
		wr({I2C_ADDR_DEF, 1'b0}, 8'h7f);
		repeat (1700) @(negedge clk_in);
		note(1'b0, expo(8'h7f, 1'b0));
		repeat (400) @(negedge clk_in);
		note(1'b0, expo(8'h40, 1'b1));
		repeat (500) @(negedge clk_in);
		rd();
		note(1'b1, {9'h001, 8'hc0});
		wr({I2C_ADDR_DEF, 1'b0}, 8'h25);
		note(1'b0, expo(8'h25, 1'b0));
		repeat (2) @(negedge clk_in);
		tally_and_finish();
	end
endmodule
